// [hdl/tlsf_pkg.sv]
// constants and helpers for the temperature limit status filter
package tlsf_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PTR_W = 8;
    localparam int unsigned CHAN_W = 2;
    localparam int unsigned FIELD_W = 3;
    localparam int unsigned CNT_W = 3;

    // pointer addresses
    localparam logic [PTR_W-1:0] PTR_STATUS = 8'h02;
    localparam logic [PTR_W-1:0] PTR_HYST = 8'h21;
    localparam logic [PTR_W-1:0] PTR_FILTER = 8'h22;
    localparam logic [PTR_W-1:0] PTR_FAULT = 8'h23;
    localparam logic [PTR_W-1:0] PTR_MASK = 8'h24;
    localparam logic [PTR_W-1:0] PTR_HIGH = 8'h25;
    localparam logic [PTR_W-1:0] PTR_LOW = 8'h26;
    localparam logic [PTR_W-1:0] PTR_OTEMP = 8'h27;

    // reset values
    localparam logic [DATA_W-1:0] HYST_RESET = 8'h0a;
    localparam logic [DATA_W-1:0] FILTER_RESET = 8'h70;
    localparam logic [DATA_W-1:0] MASK_RESET = 8'hff;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    // filter register layout
    localparam int unsigned FILT_OT_LSB = 4;
    localparam int unsigned FILT_WARN_LSB = 1;
    localparam logic [DATA_W-1:0] FILTER_WMASK = 8'h7e;

    // summary status bit positions
    localparam int unsigned STAT_HIGH_BIT = 4;
    localparam int unsigned STAT_LOW_BIT = 3;
    localparam int unsigned STAT_FAULT_BIT = 2;
    localparam int unsigned STAT_OTEMP_BIT = 1;

    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
    localparam logic [CNT_W-1:0] CNT_MAX = 3'h4;

    // count field code to number of conversions needed (1..4)
    function automatic logic [CNT_W-1:0] tlsf_need(input logic [FIELD_W-1:0] code);
        logic [CNT_W-1:0] n;
        n = CNT_ONE;
        n = n + {2'h0, code[0]} + {2'h0, code[1]} + {2'h0, code[2]};
        return n;
    endfunction
endpackage

// [hdl/tlsf_filter.sv]
// consecutive out-of-limit counter for one channel and one pin
`timescale 1ns/1ns
module tlsf_filter (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // conversion of this channel
    input wire logic conv_hit,
    input wire logic cond,
    input wire logic [tlsf_pkg::CNT_W-1:0] need,
    // filtered result
    output logic active_r
);
    import tlsf_pkg::*;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    // saturate so a long fault never wraps back to inactive
    always_comb begin
        cnt_nxt = cnt_r;
        if (conv_hit) begin
            if (!cond) begin
                cnt_nxt = '0;
            end else if (cnt_r != CNT_MAX) begin
                cnt_nxt = cnt_r + CNT_ONE;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            active_r <= 1'b0;
        end else if (conv_hit) begin
            active_r <= (cnt_nxt >= need);
        end
    end
endmodule

// [hdl/tlsf_top.sv]
// limit status, fault flags and pin filtering of the temperature monitor
// Behaviour
// - filter register at 22h, reset 70h
// - overtemp count D6-D4, warn D3-D1
// - codes 000/001/011/111 need 1-4 conversions
// - filter affects pins, not status flags
// - hysteresis register at 21h, reset 0Ah
// - hysteresis is one field D7-D0
// - hysteresis unsigned degrees, any code to FF
// - fault bit 2 for remote channel 2
// - fault bit 1 for remote channel 1
// - channel errors assert warning pin only where mask bit set
// - high status bit on high limit exceeded
// - summary high flag from any high bit
// - low status bit below low limit
// - summary low flag from any low bit
// - overtemp status bit above overtemp limit
// - summary overtemp flag from any bit
`timescale 1ns/1ns
module tlsf_top #(
    parameter int unsigned NCHAN = 3
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port from the two-wire front end
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [tlsf_pkg::PTR_W-1:0] reg_ptr,
    input wire logic [tlsf_pkg::DATA_W-1:0] reg_wdata,
    output logic [tlsf_pkg::DATA_W-1:0] reg_rdata_r,
    // conversion results, one channel per pulse
    input wire logic conv_valid,
    input wire logic [tlsf_pkg::CHAN_W-1:0] conv_chan,
    input wire logic [tlsf_pkg::DATA_W-1:0] conv_temp,
    input wire logic [tlsf_pkg::DATA_W-1:0] high_limit,
    input wire logic [tlsf_pkg::DATA_W-1:0] low_limit,
    input wire logic [tlsf_pkg::DATA_W-1:0] otemp_limit,
    input wire logic diode_open,
    // alarm pins, active high level
    output logic warn_active_r,
    output logic otemp_active_r
);
    import tlsf_pkg::*;

    logic [DATA_W-1:0] hysteresis_value_r;
    logic [DATA_W-1:0] filter_r;
    logic [DATA_W-1:0] mask_r;
    logic [NCHAN-1:0] high_stat_r;
    logic [NCHAN-1:0] low_stat_r;
    logic [NCHAN-1:0] otemp_stat_r;
    logic [NCHAN-1:0] fault_r;
    logic [NCHAN-1:0] otemp_stat_nxt;
    logic [NCHAN-1:0] warn_hit;
    logic [NCHAN-1:0] otemp_hit;
    logic [DATA_W-1:0] status_byte;
    logic [DATA_W-1:0] fault_byte;
    logic [DATA_W-1:0] read_nxt;
    logic [CNT_W-1:0] warn_need;
    logic [CNT_W-1:0] otemp_need;
    logic is_high;
    logic is_low;
    logic above_ot;
    logic below_release;
    logic [DATA_W:0] release_point;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hysteresis_value_r <= HYST_RESET;
        end else if (reg_wr && reg_ptr == PTR_HYST) begin
            hysteresis_value_r <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            filter_r <= FILTER_RESET;
        end else if (reg_wr && reg_ptr == PTR_FILTER) begin
            // D7 and D0 held at zero
            filter_r <= reg_wdata & FILTER_WMASK;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mask_r <= MASK_RESET;
        end else if (reg_wr && reg_ptr == PTR_MASK) begin
            mask_r <= reg_wdata;
        end
    end

    assign warn_need = tlsf_need(filter_r[FILT_WARN_LSB +: FIELD_W]);
    assign otemp_need = tlsf_need(filter_r[FILT_OT_LSB +: FIELD_W]);

    // limit compares on the current conversion
    assign is_high = conv_temp > high_limit;
    assign is_low = conv_temp < low_limit;
    assign above_ot = conv_temp > otemp_limit;
    // unsigned subtraction, a wide result keeps codes up to ff
    assign release_point = {1'b0, otemp_limit} - {1'b0, hysteresis_value_r};
    // negative release point never clears, the hazard of a too large value
    assign below_release = !release_point[DATA_W] &&
                           ({1'b0, conv_temp} < release_point);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            high_stat_r <= '0;
        end else if (conv_valid && conv_chan < NCHAN) begin
            high_stat_r[conv_chan] <= is_high;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            low_stat_r <= '0;
        end else if (conv_valid && conv_chan < NCHAN) begin
            low_stat_r[conv_chan] <= is_low;
        end
    end

    always_comb begin
        otemp_stat_nxt = otemp_stat_r;
        if (conv_valid && conv_chan < NCHAN) begin
            if (above_ot) begin
                otemp_stat_nxt[conv_chan] = 1'b1;
            end else if (below_release) begin
                otemp_stat_nxt[conv_chan] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            otemp_stat_r <= '0;
        end else begin
            otemp_stat_r <= otemp_stat_nxt;
        end
    end

    // remote diode faults, local channel never faults
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fault_r <= '0;
        end else if (conv_valid && conv_chan < NCHAN && conv_chan != '0) begin
            fault_r[conv_chan] <= diode_open;
        end
    end

    // per-channel consecutive filters for both pins
    genvar ch;
    generate
        for (ch = 0; ch < NCHAN; ch++) begin : g_chan
            logic hit_now;
            assign hit_now = conv_valid && (conv_chan == CHAN_W'(ch));
            // filters sit only on the pin path
            tlsf_filter u_warn (
                .mclk(mclk),
                .rst(rst),
                .conv_hit(hit_now),
                .cond(is_high || is_low || (ch != 0 && diode_open)),
                .need(warn_need),
                .active_r(warn_hit[ch])
            );
            tlsf_filter u_otemp (
                .mclk(mclk),
                .rst(rst),
                .conv_hit(hit_now),
                .cond(otemp_stat_nxt[ch]),
                .need(otemp_need),
                .active_r(otemp_hit[ch])
            );
        end
    endgenerate

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            warn_active_r <= 1'b0;
        end else begin
            warn_active_r <= |(warn_hit & mask_r[NCHAN-1:0]);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            otemp_active_r <= 1'b0;
        end else begin
            otemp_active_r <= |otemp_hit;
        end
    end

    always_comb begin
        status_byte = ZERO_BYTE;
        status_byte[STAT_HIGH_BIT] = |high_stat_r;
        status_byte[STAT_LOW_BIT] = |low_stat_r;
        status_byte[STAT_OTEMP_BIT] = |otemp_stat_r;
        status_byte[STAT_FAULT_BIT] = |fault_r;
        fault_byte = ZERO_BYTE;
        fault_byte[NCHAN-1:0] = fault_r;
    end

    // unmapped pointers read as zero
    always_comb begin
        read_nxt = ZERO_BYTE;
        case (reg_ptr)
            PTR_STATUS: read_nxt = status_byte;
            PTR_HYST: read_nxt = hysteresis_value_r;
            PTR_FILTER: read_nxt = filter_r;
            PTR_FAULT: read_nxt = fault_byte;
            PTR_MASK: read_nxt = mask_r;
            PTR_HIGH: read_nxt[NCHAN-1:0] = high_stat_r;
            PTR_LOW: read_nxt[NCHAN-1:0] = low_stat_r;
            PTR_OTEMP: read_nxt[NCHAN-1:0] = otemp_stat_r;
            default: read_nxt = ZERO_BYTE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata_r <= ZERO_BYTE;
        end else if (reg_rd) begin
            reg_rdata_r <= read_nxt;
        end
    end
endmodule

// [test/tlsf_props.sv]
// port checks for the limit status filter
`timescale 1ns/1ns
module tlsf_props #(
    parameter int unsigned NCHAN = 3
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [tlsf_pkg::PTR_W-1:0] reg_ptr,
    input wire logic [tlsf_pkg::DATA_W-1:0] reg_rdata_r,
    // conversions and pin
    input wire logic conv_valid,
    input wire logic [tlsf_pkg::CHAN_W-1:0] conv_chan,
    input wire logic [tlsf_pkg::DATA_W-1:0] conv_temp,
    input wire logic [tlsf_pkg::DATA_W-1:0] high_limit,
    input wire logic [tlsf_pkg::DATA_W-1:0] low_limit,
    input wire logic [tlsf_pkg::DATA_W-1:0] otemp_limit,
    input wire logic otemp_active_r
);
    import tlsf_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    filt_zero_a: assert property (reg_rd && reg_ptr == PTR_FILTER
        |=> !reg_rdata_r[7] && !reg_rdata_r[0]) else $error("filter spare bit set");
    fault_zero_a: assert property (reg_rd && reg_ptr == PTR_FAULT
        |=> reg_rdata_r[7:3] == 5'h00 && !reg_rdata_r[0]) else $error("fault spare bit set");
    // pin only moves on the second edge after a conversion
    ot_rise_a: assert property ($rose(otemp_active_r)
        |-> $past(conv_valid, 2)) else $error("pin early");
    high_set_a: assert property (conv_valid && conv_chan == 2'h1 && conv_temp > high_limit
        ##1 !conv_valid ##1 reg_rd && reg_ptr == PTR_HIGH |=> reg_rdata_r[1])
        else $error("high bit missing");
    high_sum_a: assert property (conv_valid && conv_chan == 2'h1 && conv_temp > high_limit
        ##1 !conv_valid ##1 reg_rd && reg_ptr == PTR_STATUS |=> reg_rdata_r[STAT_HIGH_BIT])
        else $error("high summary missing");
    low_set_a: assert property (conv_valid && conv_chan == 2'h2 && conv_temp < low_limit
        ##1 !conv_valid ##1 reg_rd && reg_ptr == PTR_LOW |=> reg_rdata_r[2])
        else $error("low bit missing");
    low_sum_a: assert property (conv_valid && conv_chan == 2'h2 && conv_temp < low_limit
        ##1 !conv_valid ##1 reg_rd && reg_ptr == PTR_STATUS |=> reg_rdata_r[STAT_LOW_BIT])
        else $error("low summary missing");
    ot_set_a: assert property (conv_valid && conv_chan == 2'h1 && conv_temp > otemp_limit
        ##1 !conv_valid ##1 reg_rd && reg_ptr == PTR_OTEMP |=> reg_rdata_r[1])
        else $error("overtemp bit missing");
endmodule

// [test/tlsf_host.sv]
// register host model, one byte per access
`timescale 1ns/1ns
module tlsf_host (
    // clock
    input wire logic mclk,
    // register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [tlsf_pkg::PTR_W-1:0] reg_ptr,
    output logic [tlsf_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [tlsf_pkg::DATA_W-1:0] reg_rdata_r
);
    import tlsf_pkg::*;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_ptr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic step;
        @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [PTR_W-1:0] p, input logic [DATA_W-1:0] d);
        step();
        reg_wr = 1'b1;
        reg_ptr = p;
        reg_wdata = d;
        step();
        reg_wr = 1'b0;
        // released lines flip so a stale byte never looks valid
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [PTR_W-1:0] p, output logic [DATA_W-1:0] d);
        step();
        reg_rd = 1'b1;
        reg_ptr = p;
        step();
        reg_rd = 1'b0;
        reg_ptr = ~p;
        d = reg_rdata_r;
    endtask
endmodule

// [test/tlsf_top_test.sv]
// self-checking bench for the limit status filter
`timescale 1ns/1ns
module tlsf_top_test;
    import tlsf_pkg::*;
    logic mclk, rst, reg_wr, reg_rd, conv_valid, diode_open, warn_active_r, otemp_active_r;
    logic [PTR_W-1:0] reg_ptr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata_r, conv_temp, high_limit, low_limit, otemp_limit, rv;
    logic [CHAN_W-1:0] conv_chan;
    logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    int error_cnt = 0;
    int checked = 0;
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    tlsf_top u_dut (.mclk, .rst, .reg_wr, .reg_rd, .reg_ptr, .reg_wdata, .reg_rdata_r,
        .conv_valid, .conv_chan, .conv_temp, .high_limit, .low_limit, .otemp_limit,
        .diode_open, .warn_active_r, .otemp_active_r);
    tlsf_host u_host (.mclk, .reg_wr, .reg_rd, .reg_ptr, .reg_wdata, .reg_rdata_r);
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [7:0] p, input logic [7:0] exp);
        u_host.rd(p, rv);
        check(rv, exp);
    endtask
    task automatic conv(input logic [1:0] ch, input logic [7:0] t, input logic op);
        u_host.step();
        conv_valid = 1'b1;
        conv_chan = ch;
        conv_temp = t;
        diode_open = op;
        u_host.step();
        conv_valid = 1'b0;
        conv_temp = ~t;
        diode_open = ~op;
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        conv_valid = 1'b0;
        conv_chan = 2'h0;
        conv_temp = 8'h00;
        diode_open = 1'b0;
        high_limit = 8'h78;
        low_limit = 8'h0a;
        otemp_limit = 8'h5a;
        repeat (2) @(posedge mclk);
        #1 rst = 1'b0;
        chk_rd(8'h22, 8'h70);
        chk_rd(8'h21, 8'h0a);
        chk_rd(PTR_MASK, 8'hff);
        u_host.wr(8'h22, 8'hff);
        chk_rd(8'h22, 8'h7e);
        u_host.wr(8'h21, 8'hff);
        chk_rd(8'h21, 8'hff);
        u_host.wr(8'h21, 8'h96);
        chk_rd(8'h21, 8'h96);
        chk_rd(8'h80, 8'h00);
        u_host.wr(8'h21, 8'h05);
        for (int i = 0; i < 4; i++) begin
            u_host.wr(8'h22, {1'b0, codes[i], 4'h0});
            for (int k = 0; k <= i; k++) begin
                conv(2'h1, 8'h64, 1'b0);
                if (k == 0) chk_rd(PTR_STATUS, 8'h02);
                u_host.step();
                check({7'h0, otemp_active_r}, {7'h0, k == i});
            end
            conv(2'h1, 8'h32, 1'b0);
            chk_rd(PTR_OTEMP, 8'h00);
            check({7'h0, otemp_active_r}, 8'h00);
        end
        conv(2'h1, 8'h64, 1'b0);
        chk_rd(PTR_OTEMP, 8'h02);
        conv(2'h1, 8'h58, 1'b0);
        chk_rd(PTR_OTEMP, 8'h02);
        conv(2'h1, 8'h54, 1'b0);
        chk_rd(PTR_OTEMP, 8'h00);
        conv(2'h1, 8'h82, 1'b0);
        chk_rd(PTR_HIGH, 8'h02);
        check({7'h0, warn_active_r}, 8'h01);
        conv(2'h1, 8'h82, 1'b0);
        chk_rd(PTR_STATUS, 8'h12);
        conv(2'h2, 8'h05, 1'b0);
        chk_rd(PTR_LOW, 8'h04);
        conv(2'h2, 8'h05, 1'b1);
        chk_rd(PTR_STATUS, 8'h1e);
        chk_rd(PTR_FAULT, 8'h04);
        conv(2'h1, 8'h32, 1'b1);
        chk_rd(PTR_FAULT, 8'h06);
        u_host.wr(PTR_FAULT, 8'hff);
        chk_rd(PTR_FAULT, 8'h06);
        u_host.wr(PTR_MASK, 8'h00);
        chk_rd(PTR_MASK, 8'h00);
        check({7'h0, warn_active_r}, 8'h00);
        u_host.wr(PTR_MASK, 8'h02);
        chk_rd(PTR_MASK, 8'h02);
        check({7'h0, warn_active_r}, 8'h01);
        // warn code 001 needs two conversions
        u_host.wr(PTR_FILTER, 8'h02);
        conv(2'h1, 8'h32, 1'b0);
        conv(2'h1, 8'h82, 1'b0);
        u_host.step();
        check({7'h0, warn_active_r}, 8'h00);
        conv(2'h1, 8'h82, 1'b0);
        u_host.step();
        check({7'h0, warn_active_r}, 8'h01);
        tally_and_finish();
    end
endmodule
bind tlsf_top tlsf_props #(.NCHAN(NCHAN)) u_props (.mclk, .rst, .reg_wr, .reg_rd, .reg_ptr,
    .reg_rdata_r, .conv_valid, .conv_chan, .conv_temp, .high_limit, .low_limit,
    .otemp_limit, .otemp_active_r);
